// File: bench/ch5_cal_chk.sv
// Checker for the channel 5 calibration register slice.
// Assumes it is bound to ch5_cal_regs and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
`include "ch5_cal_defines.svh"
module ch5_cal_chk
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [5:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic [15:0] i_reg_wdata,
   input wire logic i_reg_rd,
   input wire logic [15:0] o_reg_rdata,
   input wire logic o_reg_rvalid,
   input wire logic i_sample_valid,
   input wire logic o_result_valid,
   input wire logic [23:0] o_offset_code,
   input wire logic [23:0] o_gain_code
);
   // ****
   // Port relations
   // ****
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   a_read_answer: assert property (i_reg_rd |=> o_reg_rvalid) else $error("read not answered");
   a_offset_high: assert property (i_reg_wr && i_reg_addr == 6'h23 |=>
      o_offset_code[23:8] == $past(i_reg_wdata)) else $error("offset high not stored");
   a_offset_low: assert property (i_reg_wr && i_reg_addr == 6'h24 |=>
      o_offset_code[7:0] == $past(i_reg_wdata[15:8])) else $error("offset low not stored");
   a_gain_high: assert property (i_reg_wr && i_reg_addr == 6'h25 |=>
      o_gain_code[23:8] == $past(i_reg_wdata)) else $error("gain high not stored");
   a_gain_low: assert property (i_reg_wr && i_reg_addr == 6'h26 |=>
      o_gain_code[7:0] == $past(i_reg_wdata[15:8])) else $error("gain low not stored");
   a_low_byte_zero: assert property (i_reg_rd && i_reg_addr inside {6'h24, 6'h26} |=>
      o_reg_rdata[7:0] == 8'h00) else $error("reserved byte not zero");
   a_checksum_ro: assert property (i_reg_wr && i_reg_addr == 6'h3E |=>
      $stable(o_offset_code) && $stable(o_gain_code)) else $error("checksum write changed codes");
   a_readback_high: assert property (i_reg_rd && !i_reg_wr && i_reg_addr == 6'h23 |=>
      o_reg_rdata == $past(o_offset_code[23:8])) else $error("offset readback wrong");
   a_gain_unity: assert property ($fell(i_rst) |->
      o_gain_code == 24'h800000 && o_offset_code == 24'h000000) else $error("reset codes wrong");
   a_result_timing: assert property (i_sample_valid |-> ##2 o_result_valid) else $error("result late");
   // Main scenarios reached
   c_offset_write: cover property (i_reg_wr && i_reg_addr == 6'h23);
   c_checksum_read: cover property (i_reg_rd && i_reg_addr == 6'h3E);
   c_result: cover property (o_result_valid);
endmodule : ch5_cal_chk
bind ch5_cal_regs ch5_cal_chk u_chk (.i_clk, .i_rst, .i_reg_addr, .i_reg_wr, .i_reg_wdata, .i_reg_rd,
   .o_reg_rdata, .o_reg_rvalid, .i_sample_valid, .o_result_valid, .o_offset_code, .o_gain_code);
`default_nettype wire

// File: bench/ch5_host_model.sv
// Host controller model driving the register command port.
// Assumes one-cycle strobes and a one-cycle read answer.
`timescale 1ns/1ns
`default_nettype none
`include "ch5_cal_defines.svh"
module ch5_host_model
(
   input wire logic i_clk,
   input wire logic [15:0] i_reg_rdata,
   input wire logic i_reg_rvalid,
   output logic [5:0] o_reg_addr,
   output logic o_reg_wr,
   output logic [15:0] o_reg_wdata,
   output logic o_reg_rd
);
   initial
   begin
      o_reg_addr = 6'h00;
      o_reg_wr = 1'b0;
      o_reg_wdata = 16'h0000;
      o_reg_rd = 1'b0;
   end
   // One write strobe, data scrambled afterwards so stale values never pass
   task automatic write_reg(input logic [5:0] addr, input logic [15:0] data);
      @(negedge i_clk);
      o_reg_addr = addr;
      o_reg_wdata = (addr == `RESERVED_WORD_ADDR) ? 16'h0000 : data;
      o_reg_wr = 1'b1;
      @(negedge i_clk);
      o_reg_wr = 1'b0;
      o_reg_wdata = ~o_reg_wdata;
   endtask : write_reg
   // Missing answer yields unknown data, which no compare accepts
   task automatic read_reg(input logic [5:0] addr, output logic [15:0] data);
      @(negedge i_clk);
      o_reg_addr = addr;
      o_reg_rd = 1'b1;
      @(negedge i_clk);
      o_reg_rd = 1'b0;
      o_reg_addr = ~addr;
      data = (i_reg_rvalid === 1'b1) ? i_reg_rdata : 16'hXXXX;
   endtask : read_reg
endmodule : ch5_host_model
`default_nettype wire

// File: bench/test_ch5_cal_regs.sv
// Testbench for the channel 5 calibration register slice.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ns
`default_nettype none
`include "ch5_cal_defines.svh"
module test_ch5_cal_regs;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic [5:0] addr;
   logic wr, rd, s_valid, r_valid, rvalid;
   logic [15:0] wdata, rdata, crc_a;
   logic [23:0] sample = 24'h000000;
   logic [23:0] result, offset_code, gain_code;
   int err_count = 0;
   int compares = 0;
   int cycles = 0;
   logic [5:0] map_a[6] = '{6'h23, 6'h24, 6'h25, 6'h26, 6'h3E, 6'h3F};
   logic [15:0] rst_v[6] = '{16'h0000, 16'h0000, 16'h8000, 16'h0000, 16'h0000, 16'h0000};
   logic [15:0] back_v[5] = '{16'hFFFF, 16'hFF00, 16'hFFFF, 16'hFF00, 16'h0000};
   // Correction cases: offset words, gain high word, sample, result
   logic [15:0] c_oh[5] = '{16'hFFFF, 16'h0000, 16'hFFFF, 16'h0000, 16'h0000};
   logic [15:0] c_ol[5] = '{16'hFF00, 16'h0400, 16'hFF00, 16'h0100, 16'h0000};
   logic [15:0] c_g[5] = '{16'h8000, 16'h4000, 16'h8000, 16'hFFFF, 16'h4000};
   logic [23:0] c_s[5] = '{24'h000005, 24'h000014, 24'h7FFFFF, 24'h800000, 24'hFFFFFF};
   logic [23:0] c_r[5] = '{24'h000006, 24'h000008, 24'h7FFFFF, 24'h800000, 24'hFFFFFF};
   initial s_valid = 1'b0;
   always #5 i_clk = ~i_clk;
   ch5_cal_regs dut (.i_clk(i_clk), .i_rst(i_rst), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata),
      .i_reg_rd(rd), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_sample(sample),
      .i_sample_valid(s_valid), .o_result(result), .o_result_valid(r_valid),
      .o_offset_code(offset_code), .o_gain_code(gain_code));
   ch5_host_model host (.i_clk(i_clk), .i_reg_rdata(rdata), .i_reg_rvalid(rvalid), .o_reg_addr(addr),
      .o_reg_wr(wr), .o_reg_wdata(wdata), .o_reg_rd(rd));
   // ****
   // Shared tasks
   // ****
   task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
      compares++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   // Reference checksum: seeded CRC over the stored word images, MSB first
   function automatic logic [15:0] ref_crc(input logic [15:0] w[5]);
      logic [15:0] c;
      c = `CHECKSUM_SEED;
      foreach (w[k])
      begin
         for (int b = 15; b >= 0; b--)
         begin
            c = (c[15] ^ w[k][b]) ? ({c[14:0], 1'b0} ^ `CHECKSUM_POLY) : {c[14:0], 1'b0};
         end
      end
      ref_crc = c;
   endfunction : ref_crc
   task automatic give_verdict;
      $display("Comparisons %0d, mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : give_verdict
   task automatic reg_check(input logic [5:0] a, input logic [15:0] exp);
      logic [15:0] v;
      host.read_reg(a, v);
      check($sformatf("register %h", a), {8'h00, v}, {8'h00, exp});
   endtask : reg_check
   // Result is awaited for up to four falling edges after the sample strobe drops
   task automatic sample_check(input logic [23:0] s, input logic [23:0] exp);
      @(negedge i_clk);
      sample = s;
      s_valid = 1'b1;
      @(negedge i_clk);
      s_valid = 1'b0;
      sample = ~s;
      for (int n = 0; n < 4 && r_valid !== 1'b1; n++) @(negedge i_clk);
      check("result valid", {23'h000000, r_valid}, 24'h000001);
      check("corrected result", result, exp);
   endtask : sample_check
   // Hang guard, well above the hundred or so cycles the run needs
   always @(posedge i_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         err_count++;
         give_verdict();
      end
   end
   // ****
   // Main sequence
   // ****
   initial
   begin
      repeat (20) @(negedge i_clk);
      i_rst = 1'b0;
      check("gain code", gain_code, 24'h800000);
      check("offset code", offset_code, 24'h000000);
      foreach (rst_v[i]) reg_check(map_a[i], rst_v[i]);
      foreach (back_v[i]) host.write_reg(map_a[i == 4 ? 5 : i], 16'hFFFF);
      foreach (back_v[i]) reg_check(map_a[i == 4 ? 5 : i], back_v[i]);
      check("offset code", offset_code, 24'hFFFFFF);
      check("gain code", gain_code, 24'hFFFFFF);
      host.read_reg(6'h3E, crc_a);
      check("map checksum", {8'h00, crc_a}, {8'h00, ref_crc(back_v)});
      host.write_reg(6'h3E, ~crc_a);
      reg_check(6'h3E, crc_a);
      reg_check(6'h10, 16'h0000);
      host.write_reg(6'h26, 16'h0000);
      foreach (c_r[i])
      begin
         host.write_reg(6'h23, c_oh[i]);
         host.write_reg(6'h24, c_ol[i]);
         host.write_reg(6'h25, c_g[i]);
         sample_check(c_s[i], c_r[i]);
      end
      // Second reset in mid-run: stored words and checksum fall back to reset codes
      @(negedge i_clk);
      i_rst = 1'b1;
      repeat (2) @(negedge i_clk);
      i_rst = 1'b0;
      check("offset code", offset_code, 24'h000000);
      check("gain code", gain_code, 24'h800000);
      reg_check(6'h3E, 16'h0000);
      give_verdict();
   end
endmodule : test_ch5_cal_regs
`default_nettype wire

// File: design/ch5_cal_correct.sv
// Offset and gain correction pipeline for channel 5 conversion results.
// Assumes offset and gain are held steady by the register slice around it.
`timescale 1ns/1ns
`default_nettype none
`include "ch5_cal_defines.svh"

module ch5_cal_correct
   import ch5_cal_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [`SAMPLE_W-1:0] i_sample,
   input wire logic i_sample_valid,
   input wire logic [`SAMPLE_W-1:0] i_offset,
   input wire logic [`SAMPLE_W-1:0] i_gain,
   output logic [`SAMPLE_W-1:0] o_result,
   output logic o_result_valid
);

   corr_state_t s_q;
   corr_state_t s_d;

   // Scale by gain (unity at 800000h) and clamp to the signed 24-bit range
   function automatic logic [`SAMPLE_W-1:0] scale_sat(input logic signed [`SAMPLE_W:0] diff,
                                                      input logic [`SAMPLE_W-1:0] gain);
      logic signed [2*`SAMPLE_W+1:0] prod;
      logic signed [2*`SAMPLE_W+1:0] shifted;
      prod = diff * $signed({1'b0, gain});
      shifted = prod >>> `GAIN_FRAC_BITS;
      if (shifted > $signed({{(`SAMPLE_W+3){1'b0}}, {(`SAMPLE_W-1){1'b1}}}))
      begin
         scale_sat = {1'b0, {(`SAMPLE_W-1){1'b1}}};
      end
      else if (shifted < -$signed({{(`SAMPLE_W+2){1'b0}}, 1'b1, {(`SAMPLE_W-1){1'b0}}}))
      begin
         scale_sat = {1'b1, {(`SAMPLE_W-1){1'b0}}};
      end
      else
      begin
         scale_sat = shifted[`SAMPLE_W-1:0];
      end
   endfunction : scale_sat

   // Two stages: subtract, then multiply; keeps the multiplier off the adder path
   always_comb
   begin
      s_d = s_q;
      s_d.diff_valid = i_sample_valid;
      if (i_sample_valid)
      begin
         s_d.diff = $signed({i_sample[`SAMPLE_W-1], i_sample}) -
                    $signed({i_offset[`SAMPLE_W-1], i_offset});
      end
      s_d.out_valid = s_q.diff_valid;
      if (s_q.diff_valid)
      begin
         s_d.out = scale_sat(s_q.diff, i_gain);
      end
   end

   // State register
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign o_result = s_q.out;
   assign o_result_valid = s_q.out_valid;

endmodule : ch5_cal_correct

`default_nettype wire

// File: design/ch5_cal_defines.svh
// Constants for the channel 5 calibration and checksum register slice.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef CH5_CAL_DEFINES_SVH
`define CH5_CAL_DEFINES_SVH

// ****************************************************************
// Register access port
// ****************************************************************
`define CH5_ADDR_W 6
`define CH5_WORD_W 16

// ****************************************************************
// Register addresses (word addresses on the command port)
// ****************************************************************
`define CH5_OFFSET_UPPER_ADDR 6'h23
`define CH5_OFFSET_LOWER_ADDR 6'h24
`define CH5_GAIN_UPPER_ADDR 6'h25
`define CH5_GAIN_LOWER_ADDR 6'h26
`define REGISTER_MAP_CHECKSUM_ADDR 6'h3E
`define RESERVED_WORD_ADDR 6'h3F

// ****************************************************************
// Field positions
// ****************************************************************
`define LOW_FIELD_MSB 15
`define LOW_FIELD_LSB 8

// ****************************************************************
// Reset values
// ****************************************************************
`define CH5_OFFSET_UPPER_RST 16'h0000
`define CH5_OFFSET_LOWER_RST 8'h00
`define CH5_GAIN_UPPER_RST 16'h8000
`define CH5_GAIN_LOWER_RST 8'h00
`define REGISTER_MAP_CHECKSUM_RST 16'h0000
`define RESERVED_WORD_RST 16'h0000
`define READ_ZERO 16'h0000

// ****************************************************************
// Checksum and datapath
// ****************************************************************
`define CHECKSUM_POLY 16'h1021
`define CHECKSUM_SEED 16'hFFFF
`define SAMPLE_W 24
`define GAIN_FRAC_BITS 23

`endif

// File: design/ch5_cal_pkg.sv
// Types shared by the channel 5 calibration register slice and its datapath.
// Assumes ch5_cal_defines.svh is on the include path.
`include "ch5_cal_defines.svh"

package ch5_cal_pkg;

   // ****************************************************************
   // State of the register slice
   // ****************************************************************
   typedef struct packed {
      logic [`CH5_WORD_W-1:0] offset_upper;
      logic [7:0] offset_low;
      logic [`CH5_WORD_W-1:0] gain_upper;
      logic [7:0] gain_low;
      logic [`CH5_WORD_W-1:0] reserved_word;
      logic [`CH5_WORD_W-1:0] checksum;
      logic checksum_pend;
      logic [`CH5_WORD_W-1:0] rd_data;
      logic rd_valid;
   } regs_state_t;

   // ****************************************************************
   // State of the correction pipeline
   // ****************************************************************
   typedef struct packed {
      logic diff_valid;
      logic signed [`SAMPLE_W:0] diff;
      logic out_valid;
      logic [`SAMPLE_W-1:0] out;
   } corr_state_t;

endpackage : ch5_cal_pkg

// File: design/ch5_cal_regs.sv
// Channel 5 offset and gain calibration registers, register map checksum word
// and reserved word, plus the correction pipeline they steer.
// Assumes a command decoder outside presents word addresses with one-cycle
// read and write strobes, synchronous to i_clk.
`timescale 1ns/1ns
`default_nettype none
`include "ch5_cal_defines.svh"

// Behaviour
// - Offset bits 23..8 live in read/write word 23h, zero after reset.
// - Offset bits 7..0 sit in upper byte of 24h; lower byte reads zero.
// - Assembled 24-bit offset is a signed two's complement value.
// - Gain bits 23..8 live in read/write word 25h, unsigned.
// - Word 25h resets to 8000h, unity gain; gain spans 0 to just under 2.
// - Gain bits 7..0 in upper byte of 26h, reset zero; lower byte reads zero.
// - Read-only checksum over the register map at 3Eh, zero after reset.
module ch5_cal_regs
   import ch5_cal_pkg::*;
#(
   parameter logic [`CH5_WORD_W-1:0] CHECKSUM_POLY = `CHECKSUM_POLY,
   parameter logic [`CH5_WORD_W-1:0] CHECKSUM_SEED = `CHECKSUM_SEED
)
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [`CH5_ADDR_W-1:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic [`CH5_WORD_W-1:0] i_reg_wdata,
   input wire logic i_reg_rd,
   output logic [`CH5_WORD_W-1:0] o_reg_rdata,
   output logic o_reg_rvalid,
   input wire logic [`SAMPLE_W-1:0] i_sample,
   input wire logic i_sample_valid,
   output logic [`SAMPLE_W-1:0] o_result,
   output logic o_result_valid,
   output logic [`SAMPLE_W-1:0] o_offset_code,
   output logic [`SAMPLE_W-1:0] o_gain_code
);

   // ****************************************************************
   // Functions
   // ****************************************************************

   // Bitwise CRC over a word stream, MSB first
   // Unrolls into one XOR tree per word; small enough for five words at this clock
   function automatic logic [`CH5_WORD_W-1:0] crc_update(input logic [`CH5_WORD_W-1:0] crc_in,
                                                         input logic [`CH5_WORD_W-1:0] word);
      logic [`CH5_WORD_W-1:0] c;
      logic fb;
      c = crc_in;
      for (int i = `CH5_WORD_W - 1; i >= 0; i--)
      begin
         fb = c[`CH5_WORD_W-1] ^ word[i];
         c = {c[`CH5_WORD_W-2:0], 1'b0};
         if (fb)
         begin
            c = c ^ CHECKSUM_POLY;
         end
      end
      crc_update = c;
   endfunction : crc_update

   // Readback image of a split low register: field in upper byte, zeros below
   function automatic logic [`CH5_WORD_W-1:0] low_word(input logic [7:0] field);
      low_word = {field, 8'h00};
   endfunction : low_word

   // ****************************************************************
   // State
   // ****************************************************************
   regs_state_t s_q;
   regs_state_t s_d;
   logic [`CH5_WORD_W-1:0] ch5_offset_lower;
   logic [`CH5_WORD_W-1:0] ch5_gain_lower;
   logic [`CH5_WORD_W-1:0] map_crc;
   logic wr_hit;

   // Readback images of the split registers
   // Reserved low bytes are not stored at all, so they can only ever read zero
   assign ch5_offset_lower = low_word(s_q.offset_low);
   assign ch5_gain_lower = low_word(s_q.gain_low);

   // Checksum over every stored word, taken from the settled registers
   always_comb
   begin
      map_crc = CHECKSUM_SEED;
      map_crc = crc_update(map_crc, s_q.offset_upper);
      map_crc = crc_update(map_crc, ch5_offset_lower);
      map_crc = crc_update(map_crc, s_q.gain_upper);
      map_crc = crc_update(map_crc, ch5_gain_lower);
      map_crc = crc_update(map_crc, s_q.reserved_word);
   end

   // A write to any stored word schedules a checksum refresh
   // Writes to the checksum word or unmapped words leave the checksum as it stands
   always_comb
   begin
      wr_hit = 1'b0;
      if (i_reg_wr)
      begin
         case (i_reg_addr)
            `CH5_OFFSET_UPPER_ADDR,
            `CH5_OFFSET_LOWER_ADDR,
            `CH5_GAIN_UPPER_ADDR,
            `CH5_GAIN_LOWER_ADDR,
            `RESERVED_WORD_ADDR:
               wr_hit = 1'b1;
            default:
               wr_hit = 1'b0;
         endcase
      end
   end

   // ****************************************************************
   // Next state: writes, checksum refresh and read data
   // ****************************************************************

   // Writes to the checksum word and unmapped words are dropped silently
   always_comb
   begin
      s_d = s_q;
      if (i_reg_wr)
      begin
         case (i_reg_addr)
            `CH5_OFFSET_UPPER_ADDR:
               s_d.offset_upper = i_reg_wdata;
            `CH5_OFFSET_LOWER_ADDR:
               s_d.offset_low = i_reg_wdata[`LOW_FIELD_MSB:`LOW_FIELD_LSB];
            `CH5_GAIN_UPPER_ADDR:
               s_d.gain_upper = i_reg_wdata;
            `CH5_GAIN_LOWER_ADDR:
               s_d.gain_low = i_reg_wdata[`LOW_FIELD_MSB:`LOW_FIELD_LSB];
            `RESERVED_WORD_ADDR:
               s_d.reserved_word = i_reg_wdata;
            default:
               s_d.reserved_word = s_q.reserved_word;
         endcase
      end

      // Refresh one cycle after the write so the new value is included
      s_d.checksum_pend = wr_hit;
      if (s_q.checksum_pend)
      begin
         s_d.checksum = map_crc;
      end

      // Reads see the state before any write in the same cycle
      s_d.rd_valid = i_reg_rd;
      if (i_reg_rd)
      begin
         case (i_reg_addr)
            `CH5_OFFSET_UPPER_ADDR:
               s_d.rd_data = s_q.offset_upper;
            `CH5_OFFSET_LOWER_ADDR:
               s_d.rd_data = ch5_offset_lower;
            `CH5_GAIN_UPPER_ADDR:
               s_d.rd_data = s_q.gain_upper;
            `CH5_GAIN_LOWER_ADDR:
               s_d.rd_data = ch5_gain_lower;
            `REGISTER_MAP_CHECKSUM_ADDR:
               s_d.rd_data = s_q.checksum;
            `RESERVED_WORD_ADDR:
               s_d.rd_data = s_q.reserved_word;
            default:
               s_d.rd_data = `READ_ZERO;
         endcase
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************

   // Reset values; checksum stays zero until the first write to a stored word
   // A reset in mid-run also drops a refresh that is still pending
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         s_q.offset_upper <= `CH5_OFFSET_UPPER_RST;
         s_q.offset_low <= `CH5_OFFSET_LOWER_RST;
         s_q.gain_upper <= `CH5_GAIN_UPPER_RST;
         s_q.gain_low <= `CH5_GAIN_LOWER_RST;
         s_q.reserved_word <= `RESERVED_WORD_RST;
         s_q.checksum <= `REGISTER_MAP_CHECKSUM_RST;
         s_q.checksum_pend <= 1'b0;
         s_q.rd_data <= `READ_ZERO;
         s_q.rd_valid <= 1'b0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ****************************************************************
   // Outputs and correction datapath
   // ****************************************************************

   // Assembled codes: offset signed, gain unsigned with unity at 800000h
   assign o_offset_code = {s_q.offset_upper, s_q.offset_low};
   assign o_gain_code = {s_q.gain_upper, s_q.gain_low};
   assign o_reg_rdata = s_q.rd_data;
   assign o_reg_rvalid = s_q.rd_valid;

   // Corrections are live: a register write takes effect on the next sample
   ch5_cal_correct u_correct (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_sample(i_sample),
      .i_sample_valid(i_sample_valid),
      .i_offset(o_offset_code),
      .i_gain(o_gain_code),
      .o_result(o_result),
      .o_result_valid(o_result_valid)
   );

endmodule : ch5_cal_regs

`default_nettype wire
